// *** design/tpw_timer.sv ***
// Purpose: 16-bit timer with three compare channels and PWM waveform modes
// Assumes: Single 10 MHz clock, AHB-Lite slave, zero wait states
// Notes:   Normal and CTC modes count and wrap but only toggle in CTC
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "tpw_defines.svh"
module tpw_timer (
	input  wire logic        CLK_IN,
	input  wire logic        RESET_N_IN,
	input  wire logic        HSEL_IN,
	input  wire logic [31:0] HADDR_IN,
	input  wire logic [1:0]  HTRANS_IN,
	input  wire logic        HWRITE_IN,
	input  wire logic [2:0]  HSIZE_IN,
	input  wire logic [31:0] HWDATA_IN,
	input  wire logic        HREADY_IN,
	output logic      [31:0] HRDATA_OUT,
	output logic             HREADYOUT_OUT,
	output logic             HRESP_OUT,
	output logic      [2:0]  COMPARE_OUTPUT_OUT,
	output logic      [2:0]  COMPARE_OUTPUT_OE_OUT
);
	import tpw_pkg::*;

	logic [9:0]  ctrl_q;
	logic [2:0]  presc_q;
	logic [2:0]  dir_bits_q;
	tpw_word_t   count_q;
	tpw_word_t   cap_top_q;
	tpw_word_t   cmp_buf_q [3];
	tpw_word_t   cmp_act_q [3];
	logic [4:0]  flags_q;
	tpw_dir_e    dir_q;
	logic [2:0]  oc_q;
	logic [10:0] div_q;
	logic        tick;
	logic        wr_pend_q;
	logic [7:0]  wr_addr_q;
	logic        rd_sel;
	tpw_wgm_e    wgm;
	tpw_word_t   top;
	logic        fast_mode, dual_mode, pfc_mode, ctc_mode, fixed_top;
	logic        at_top, at_zero, load_now;
	tpw_word_t   wmask;

	assign wgm = tpw_wgm_e'(ctrl_q[`TPW_CTRL_WGM]);

	// Action field of channel i
	function automatic tpw_act_e act_of(input logic [9:0] c, input int i);
		act_of = tpw_act_e'(c[4 + 2*i +: 2]);
	endfunction

	// Mode decode
	always_comb begin
		fast_mode = (wgm == TPW_F8) || (wgm == TPW_F9) || (wgm == TPW_F10) ||
			(wgm == TPW_F_C) || (wgm == TPW_F_A);
		pfc_mode  = (wgm == TPW_PFC_C) || (wgm == TPW_PFC_A);
		dual_mode = pfc_mode || (wgm == TPW_PC8) || (wgm == TPW_PC9) || (wgm == TPW_PC10) ||
			(wgm == TPW_PC_C) || (wgm == TPW_PC_A);
		ctc_mode  = (wgm == TPW_CTC_A) || (wgm == TPW_CTC_C);
		fixed_top = 1'b1;
		wmask     = 16'hFFFF;
		unique case (wgm)
			TPW_PC8, TPW_F8: begin
				top   = `TPW_TOP8;
				wmask = `TPW_TOP8;
			end
			TPW_PC9, TPW_F9: begin
				top   = `TPW_TOP9;
				wmask = `TPW_TOP9;
			end
			TPW_PC10, TPW_F10: begin
				top   = `TPW_TOP10;
				wmask = `TPW_TOP10;
			end
			// Register tops accept any value from 0x0003 to 0xFFFF
			TPW_PFC_C, TPW_PC_C, TPW_CTC_C, TPW_F_C: begin
				top       = cap_top_q;
				fixed_top = 1'b0;
			end
			TPW_PFC_A, TPW_PC_A, TPW_CTC_A, TPW_F_A: begin
				top       = cmp_act_q[0];
				fixed_top = 1'b0;
			end
			default: begin
				top       = 16'hFFFF;
				fixed_top = 1'b0;
			end
		endcase
	end

	assign at_top  = (count_q == top);
	assign at_zero = (count_q == 16'h0000);
	// Loads at top for single-slope and phase correct, at zero for frequency correct
	assign load_now = tick && (pfc_mode ? (at_zero && dir_q == TPW_DOWN) : at_top);

	// Prescaler: tick every N I/O clocks, N = 1, 8, 64, 256, 1024
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			div_q <= 11'h000;
		end else begin
			div_q <= tick ? 11'h000 : div_q + 11'h001;
		end
	end
	always_comb begin
		unique case (presc_q)
			3'h1: tick = 1'b1;
			3'h2: tick = (div_q == `TPW_DIV8);
			3'h3: tick = (div_q == `TPW_DIV64);
			3'h4: tick = (div_q == `TPW_DIV256);
			3'h5: tick = (div_q == `TPW_DIV1024);
			default: tick = 1'b0;
		endcase
	end

	// Bus: address phase captured, write committed in data phase
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else if (HREADY_IN) begin
			wr_pend_q <= HSEL_IN && HTRANS_IN[1] && HWRITE_IN;
			wr_addr_q <= HADDR_IN[7:0];
		end
	end
	assign rd_sel = HREADY_IN && HSEL_IN && HTRANS_IN[1] && !HWRITE_IN;

	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			HRDATA_OUT <= 32'h0000_0000;
		end else if (rd_sel) begin
			unique case (HADDR_IN[7:0])
				`TPW_OFF_CTRL:  HRDATA_OUT <= {22'h0, ctrl_q};
				`TPW_OFF_PRESC: HRDATA_OUT <= {29'h0, presc_q};
				`TPW_OFF_COUNT: HRDATA_OUT <= {16'h0, count_q};
				`TPW_OFF_CMPA:  HRDATA_OUT <= {16'h0, cmp_buf_q[0]};
				`TPW_OFF_CMPB:  HRDATA_OUT <= {16'h0, cmp_buf_q[1]};
				`TPW_OFF_CMPC:  HRDATA_OUT <= {16'h0, cmp_buf_q[2]};
				`TPW_OFF_CAPT:  HRDATA_OUT <= {16'h0, cap_top_q};
				`TPW_OFF_FLAGS: HRDATA_OUT <= {27'h0, flags_q};
				`TPW_OFF_DIR:   HRDATA_OUT <= {29'h0, dir_bits_q};
				default:        HRDATA_OUT <= 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			HREADYOUT_OUT <= 1'b0;
			HRESP_OUT     <= 1'b0;
		end else begin
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT     <= 1'b0;
		end
	end

	// Control registers
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			ctrl_q     <= 10'h000;
			presc_q    <= 3'h0;
			dir_bits_q <= 3'h0;
			cap_top_q  <= 16'h0000;
		end else if (wr_pend_q) begin
			unique case (wr_addr_q)
				`TPW_OFF_CTRL:  ctrl_q     <= HWDATA_IN[9:0];
				`TPW_OFF_PRESC: presc_q    <= HWDATA_IN[2:0];
				`TPW_OFF_DIR:   dir_bits_q <= HWDATA_IN[2:0];
				`TPW_OFF_CAPT:  cap_top_q  <= HWDATA_IN[15:0];
				default: ;
			endcase
		end
	end

	// Compare buffers and active values
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			for (int i = 0; i < 3; i++) begin
				cmp_buf_q[i] <= 16'h0000;
				cmp_act_q[i] <= 16'h0000;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (wr_pend_q && wr_addr_q == `TPW_OFF_CMPA + 8'(4*i))
					cmp_buf_q[i] <= HWDATA_IN[15:0] & wmask;
				// Non-PWM modes have no double buffer
				if (!(fast_mode || dual_mode) || load_now)
					cmp_act_q[i] <= cmp_buf_q[i];
			end
		end
	end

	// Counter, flags
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			count_q <= 16'h0000;
			dir_q   <= TPW_UP;
		end else if (wr_pend_q && wr_addr_q == `TPW_OFF_COUNT) begin
			count_q <= HWDATA_IN[15:0];
		end else if (tick) begin
			if (dual_mode) begin
				// Top held for one tick, then down; period is twice top
				if (at_top && dir_q == TPW_UP) begin
					dir_q   <= TPW_DOWN;
					count_q <= count_q - 16'h0001;
				end else if (at_zero && dir_q == TPW_DOWN) begin
					dir_q   <= TPW_UP;
					count_q <= 16'h0001;
				end else if (dir_q == TPW_UP) begin
					count_q <= count_q + 16'h0001;
				end else begin
					count_q <= count_q - 16'h0001;
				end
			end else begin
				dir_q   <= TPW_UP;
				count_q <= ((fast_mode || ctc_mode) && at_top) ? 16'h0000 : count_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			flags_q <= 5'h00;
		end else begin
			// Hardware set wins over a same-cycle software clear
			for (int i = 0; i < 5; i++) begin
				if (wr_pend_q && wr_addr_q == `TPW_OFF_FLAGS && HWDATA_IN[i])
					flags_q[i] <= 1'b0;
			end
			if (tick) begin
				for (int i = 0; i < 3; i++)
					if (count_q == cmp_act_q[i])
						flags_q[`TPW_FLG_CMPA + i] <= 1'b1;
				if (dual_mode ? (at_zero && dir_q == TPW_DOWN) : (fast_mode && at_top) || count_q == 16'hFFFF)
					flags_q[`TPW_FLG_WRAP] <= 1'b1;
				if (at_top && dir_q == TPW_UP && (wgm == TPW_PFC_C || wgm == TPW_PC_C || wgm == TPW_F_C ||
						wgm == TPW_CTC_C))
					flags_q[`TPW_FLG_CAPT] <= 1'b1;
			end
		end
	end

	// Waveform outputs
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			oc_q <= 3'h0;
		end else if (tick) begin
			for (int i = 0; i < 3; i++) begin
				tpw_act_e a;
				logic     m;
				a = act_of(ctrl_q, i);
				m = (count_q == cmp_act_q[i]);
				if (a == TPW_ACT_TOG) begin
					// Toggle only on channel A, and only when A defines top or in CTC
					if (m && i == 0 && (wgm == TPW_F_A || wgm == TPW_PC_A || wgm == TPW_PFC_A || ctc_mode))
						oc_q[i] <= ~oc_q[i];
				end else if (a != TPW_ACT_OFF && fast_mode) begin
					// Match action first so compare at top yields a constant level
					if (m)
						oc_q[i] <= (a == TPW_ACT_NINV);
					else if (at_top)
						oc_q[i] <= (a == TPW_ACT_INV);
				end else if (a != TPW_ACT_OFF && dual_mode) begin
					// Zero is met on the way down, so its match must not act as a down match
					if (m && at_zero)
						oc_q[i] <= (a == TPW_ACT_INV);
					else if (m && at_top)
						oc_q[i] <= (a == TPW_ACT_NINV);
					else if (m && dir_q == TPW_UP)
						oc_q[i] <= (a == TPW_ACT_INV);
					else if (m)
						oc_q[i] <= (a == TPW_ACT_NINV);
				end
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			COMPARE_OUTPUT_OUT    <= 3'h0;
			COMPARE_OUTPUT_OE_OUT <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				COMPARE_OUTPUT_OE_OUT[i] <= dir_bits_q[i];
				COMPARE_OUTPUT_OUT[i]    <= dir_bits_q[i] && act_of(ctrl_q, i) != TPW_ACT_OFF && oc_q[i];
			end
		end
	end

	a_cmp_flag_set: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		tick && count_q == cmp_act_q[1] |=> flags_q[`TPW_FLG_CMPB]) else $error("compare flag B not set");
	a_pc_wrap_flag: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		tick && dual_mode && at_zero && dir_q == TPW_DOWN |=> flags_q[`TPW_FLG_WRAP])
		else $error("wrap flag missed at zero");
	a_buf_load_top: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		tick && fast_mode && at_top |=> cmp_act_q[0] == $past(cmp_buf_q[0])) else $error("buffer not loaded");
	a_fast_wrap: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		tick && fast_mode && at_top && !wr_pend_q |=> count_q == 16'h0000) else $error("fast wrap missed");
	a_pin_dir_gate: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		!dir_bits_q[0] |=> !COMPARE_OUTPUT_OUT[0]) else $error("pin driven without direction");
	a_fast_set_match: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		tick && fast_mode && act_of(ctrl_q, 1) == TPW_ACT_NINV && count_q == cmp_act_q[1] |=> oc_q[1])
		else $error("non-inverted set missed");
	a_pc_up_clear: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		tick && dual_mode && act_of(ctrl_q, 1) == TPW_ACT_NINV && dir_q == TPW_UP && count_q == cmp_act_q[1] &&
		!at_top |=> !oc_q[1]) else $error("up match did not clear");
	a_pc_zero_low: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		tick && dual_mode && act_of(ctrl_q, 1) == TPW_ACT_NINV && cmp_act_q[1] == 16'h0000 && at_zero
		|=> !oc_q[1]) else $error("zero compare drove output high");
	a_no_tick_hold: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		!tick && !wr_pend_q |=> $stable(count_q)) else $error("count moved without tick");
	a_pc_top_rest: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		tick && dual_mode && dir_q == TPW_UP && count_q + 16'h0001 == top && !at_top && !wr_pend_q
		|=> count_q == top && dir_q == TPW_UP) else $error("top not reached");
	c_fast_wrap: cover property (@(posedge CLK_IN) tick && fast_mode && at_top);
	c_pc_turn: cover property (@(posedge CLK_IN) tick && dual_mode && at_top && dir_q == TPW_UP);
	c_pfc_load: cover property (@(posedge CLK_IN) load_now && pfc_mode);
endmodule // tpw_timer

// *** include/tpw_defines.svh ***
// Purpose: Constants for the 16-bit PWM waveform timer
// Assumes: 10 MHz I/O clock, AHB-Lite register access
// Notes:   Offsets are byte addresses of 32-bit words
`ifndef TPW_DEFINES_SVH
`define TPW_DEFINES_SVH
`define TPW_OFF_CTRL    8'h00
`define TPW_OFF_PRESC   8'h04
`define TPW_OFF_COUNT   8'h08
`define TPW_OFF_CMPA    8'h0C
`define TPW_OFF_CMPB    8'h10
`define TPW_OFF_CMPC    8'h14
`define TPW_OFF_CAPT    8'h18
`define TPW_OFF_FLAGS   8'h1C
`define TPW_OFF_DIR     8'h20
`define TPW_CTRL_WGM    3:0
`define TPW_CTRL_ACTA   5:4
`define TPW_CTRL_ACTB   7:6
`define TPW_CTRL_ACTC   9:8
`define TPW_FLG_WRAP    0
`define TPW_FLG_CMPA    1
`define TPW_FLG_CMPB    2
`define TPW_FLG_CMPC    3
`define TPW_FLG_CAPT    4
`define TPW_TOP8        16'h00FF
`define TPW_TOP9        16'h01FF
`define TPW_TOP10       16'h03FF
`define TPW_DIV8        11'h007
`define TPW_DIV64       11'h03F
`define TPW_DIV256      11'h0FF
`define TPW_DIV1024     11'h3FF
`define TPW_CLK_NS      100
`endif

// *** include/tpw_pkg.sv ***
// Purpose: Types for the 16-bit PWM waveform timer
// Assumes: Used with tpw_defines.svh
// Notes:   Waveform select codes follow the counter's mode table
package tpw_pkg;
	typedef enum logic [3:0] {
		TPW_NORMAL = 4'h0, TPW_PC8 = 4'h1, TPW_PC9 = 4'h2, TPW_PC10 = 4'h3,
		TPW_CTC_A = 4'h4, TPW_F8 = 4'h5, TPW_F9 = 4'h6, TPW_F10 = 4'h7,
		TPW_PFC_C = 4'h8, TPW_PFC_A = 4'h9, TPW_PC_C = 4'hA, TPW_PC_A = 4'hB,
		TPW_CTC_C = 4'hC, TPW_RSVD = 4'hD, TPW_F_C = 4'hE, TPW_F_A = 4'hF
	} tpw_wgm_e;
	typedef enum logic [1:0] {
		TPW_ACT_OFF = 2'h0, TPW_ACT_TOG = 2'h1, TPW_ACT_NINV = 2'h2, TPW_ACT_INV = 2'h3
	} tpw_act_e;
	typedef enum logic [1:0] {
		TPW_UP = 2'h0, TPW_DOWN = 2'h1
	} tpw_dir_e;
	typedef logic [15:0] tpw_word_t;
endpackage

// *** dv/tpw_pin_load.sv ***
// Purpose: Load model on the three compare output pads
// Assumes: Each pad has a weak pull-down, as a gate driver input does
// Notes:   An undriven pad reads low and never keeps its last driven level
`timescale 1ns/1ps
module tpw_pin_load (
	input  wire logic [2:0] level_in,
	input  wire logic [2:0] oe_in,
	output logic      [2:0] pad_out
);
	// Released pads fall to the pull-down level
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pad_out[i] = oe_in[i] ? level_in[i] : 1'b0;
		end
	end
endmodule // tpw_pin_load

// *** dv/tb.sv ***
// Purpose: Self-checking bench for the PWM waveform timer
// Assumes: Zero wait state AHB-Lite slave, one 10 MHz clock
// Notes:   Waveforms are measured on the loaded pads, edge to edge
`timescale 1ns/1ps
`include "tpw_defines.svh"
module tb;
	import tpw_pkg::*;
	typedef struct {
		tpw_wgm_e  wgm;
		tpw_act_e  act;
		int        ch;
		logic [2:0] ps;
		tpw_word_t capt, cmpa, cmp;
		int        per, hi;
	} tpw_row_s;
	logic        clk, rst_n, hsel, hwrite;
	logic [31:0] haddr, hwdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	wire  [31:0] hrdata;
	wire         hready, hresp;
	wire  [2:0]  pin, oe, pad;
	int          failures, checks_done, n;
	logic [31:0] f, c;
	logic [2:0]  acc;
	// Every top is at or above its compare value, so each row has matches
	tpw_row_s rows [19] = '{
		'{TPW_F_C,   TPW_ACT_NINV, 1, 3'h1, 16'h9, 16'h0, 16'h3, 10, 6},
		'{TPW_F_C,   TPW_ACT_INV,  1, 3'h2, 16'h9, 16'h0, 16'h3, 80, 32},
		'{TPW_F_C,   TPW_ACT_NINV, 1, 3'h1, 16'h9, 16'h0, 16'h0, 10, 9},
		'{TPW_F_A,   TPW_ACT_NINV, 1, 3'h1, 16'h0, 16'h7, 16'h2, 8, 5},
		'{TPW_F_A,   TPW_ACT_TOG,  0, 3'h1, 16'h0, 16'h4, 16'h4, 10, 5},
		'{TPW_PC_C,  TPW_ACT_NINV, 1, 3'h1, 16'h8, 16'h0, 16'h3, 16, 6},
		'{TPW_PC_A,  TPW_ACT_INV,  1, 3'h1, 16'h0, 16'h8, 16'h3, 16, 10},
		'{TPW_PC_A,  TPW_ACT_TOG,  0, 3'h1, 16'h0, 16'h5, 16'h5, 20, 10},
		'{TPW_PFC_C, TPW_ACT_NINV, 2, 3'h1, 16'h6, 16'h0, 16'h2, 12, 4},
		'{TPW_PFC_A, TPW_ACT_NINV, 1, 3'h1, 16'h0, 16'h6, 16'h5, 12, 10},
		'{TPW_PC8,   TPW_ACT_NINV, 1, 3'h1, 16'h0, 16'h0, 16'h40, 510, 128},
		'{TPW_PC9,   TPW_ACT_NINV, 1, 3'h1, 16'h0, 16'h0, 16'h100, 1022, 512},
		'{TPW_PC10,  TPW_ACT_NINV, 2, 3'h1, 16'h0, 16'h0, 16'h200, 2046, 1024},
		'{TPW_F8,    TPW_ACT_NINV, 1, 3'h1, 16'h0, 16'h0, 16'h80, 256, 127},
		'{TPW_F9,    TPW_ACT_INV,  2, 3'h1, 16'h0, 16'h0, 16'h100, 512, 257},
		'{TPW_F10,   TPW_ACT_NINV, 1, 3'h1, 16'h0, 16'h0, 16'h100, 1024, 767},
		'{TPW_F_C,   TPW_ACT_NINV, 1, 3'h5, 16'h3, 16'h0, 16'h1, 4096, 2048},
		'{TPW_PC_C,  TPW_ACT_NINV, 1, 3'h3, 16'h3, 16'h0, 16'h1, 384, 128},
		'{TPW_F_A,   TPW_ACT_NINV, 1, 3'h4, 16'h0, 16'h3, 16'h2, 1024, 256}
	};

	tpw_timer dut (
		.CLK_IN                (clk),
		.RESET_N_IN            (rst_n),
		.HSEL_IN               (hsel),
		.HADDR_IN              (haddr),
		.HTRANS_IN             (htrans),
		.HWRITE_IN             (hwrite),
		.HSIZE_IN              (hsize),
		.HWDATA_IN             (hwdata),
		.HREADY_IN             (hready),
		.HRDATA_OUT            (hrdata),
		.HREADYOUT_OUT         (hready),
		.HRESP_OUT             (hresp),
		.COMPARE_OUTPUT_OUT    (pin),
		.COMPARE_OUTPUT_OE_OUT (oe)
	);
	tpw_pin_load u_load (
		.level_in (pin),
		.oe_in    (oe),
		.pad_out  (pad)
	);

	initial begin
		clk = 1'b0;
		forever #(`TPW_CLK_NS / 2) clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// One single transfer; the request is held until hready is seen high
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bus(1'b0, a, 32'h0, d);
	endtask

	// Stop and park in normal mode, where compare values load at once, so a stale
	// active top cannot send the count the long way round; top never changes live
	task automatic setup(input tpw_row_s r);
		wr(`TPW_OFF_PRESC, 32'h0);
		wr(`TPW_OFF_CTRL, 32'h0);
		wr(`TPW_OFF_CAPT, 32'(r.capt));
		wr(`TPW_OFF_CMPA, 32'(r.cmpa));
		if (r.ch != 0) wr(8'(`TPW_OFF_CMPA + 4 * r.ch), 32'(r.cmp));
		wr(`TPW_OFF_COUNT, 32'h0);
		wr(`TPW_OFF_CTRL, 32'(r.wgm) | (32'(r.act) << (4 + 2 * r.ch)));
		wr(`TPW_OFF_DIR, 32'h7);
		wr(`TPW_OFF_PRESC, 32'(r.ps));
	endtask

	// Cycles and high cycles up to the next rising pad edge
	task automatic rise(input int ch, output int per, output int hi);
		logic prev;
		prev = pad[ch];
		per = 0;
		hi = 0;
		forever begin
			@(posedge clk);
			per++;
			hi += (pad[ch] === 1'b1);
			if ((prev === 1'b0 && pad[ch] === 1'b1) || per > 9000) break;
			prev = pad[ch];
		end
	endtask

	task automatic level_count(input tpw_row_s r, output int hi);
		setup(r);
		repeat (40) @(posedge clk);
		hi = 0;
		repeat (60) begin
			@(posedge clk);
			hi += (pad[r.ch] === 1'b1);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		int p, h;
		{rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		failures = 0;
		checks_done = 0;
		repeat (20) @(posedge clk);
		check({hready, hresp, oe, pin}, 32'h0);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		foreach (rows[i]) begin
			setup(rows[i]);
			repeat (3) rise(rows[i].ch, p, h);
			check(p, rows[i].per);
			check(h, rows[i].hi);
		end
		// Active top is 3; an unbuffered write of 200 would delay the wrap
		wr(`TPW_OFF_PRESC, 32'h0);
		wr(`TPW_OFF_COUNT, 32'h2);
		wr(`TPW_OFF_CMPA, 32'hC8);
		wr(`TPW_OFF_FLAGS, 32'h1F);
		wr(`TPW_OFF_PRESC, 32'h1);
		repeat (4) @(posedge clk);
		rd(`TPW_OFF_FLAGS, f);
		check(f[`TPW_FLG_WRAP], 1'b1);
		wr(`TPW_OFF_DIR, 32'h0);
		repeat (4) @(posedge clk);
		acc = 3'h0;
		repeat (30) begin
			@(posedge clk);
			acc |= pin | oe;
		end
		check(acc, 32'h0);
		wr(`TPW_OFF_DIR, 32'h2);
		repeat (4) @(posedge clk);
		check(oe, 32'h2);
		level_count('{TPW_F_C, TPW_ACT_NINV, 1, 3'h1, 16'h9, 16'h0, 16'h9, 0, 0}, n);
		check(32'(n == 0 || n == 60), 32'h1);
		level_count('{TPW_PC_C, TPW_ACT_NINV, 1, 3'h1, 16'h8, 16'h0, 16'h8, 0, 0}, n);
		check(n, 60);
		level_count('{TPW_PC_C, TPW_ACT_NINV, 1, 3'h1, 16'h8, 16'h0, 16'h0, 0, 0}, n);
		check(n, 0);
		level_count('{TPW_PC_C, TPW_ACT_INV, 1, 3'h1, 16'h8, 16'h0, 16'h0, 0, 0}, n);
		check(n, 60);
		wr(`TPW_OFF_FLAGS, 32'h1F);
		repeat (40) @(posedge clk);
		rd(`TPW_OFF_FLAGS, f);
		check(f & 32'h15, 32'h15);
		wr(`TPW_OFF_PRESC, 32'h0);
		wr(`TPW_OFF_FLAGS, 32'h1F);
		rd(`TPW_OFF_COUNT, c);
		repeat (40) @(posedge clk);
		rd(`TPW_OFF_FLAGS, f);
		check(f, 32'h0);
		rd(`TPW_OFF_COUNT, f);
		check(f, c);
		wr(`TPW_OFF_CAPT, 32'h1234);
		rd(`TPW_OFF_CAPT, f);
		check(f, 32'h1234);
		wr(`TPW_OFF_CTRL, 32'(TPW_F8));
		wr(`TPW_OFF_CMPB, 32'h1234);
		rd(`TPW_OFF_CMPB, f);
		check(f, 32'h34);
		wr(`TPW_OFF_CTRL, 32'(TPW_F9));
		wr(`TPW_OFF_CMPC, 32'hFFFF);
		rd(`TPW_OFF_CMPC, f);
		check(f, 32'h1FF);
		wr(8'h40, 32'hFFFFFFFF);
		rd(8'h40, f);
		check(f, 32'h0);
		check(hresp, 1'b0);
		// Mid-run reset: outputs drop at once, the bus answers again after release
		rst_n <= 1'b0;
		@(posedge clk);
		check({hready, hresp, oe, pin}, 32'h0);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rd(`TPW_OFF_CTRL, f);
		check(f, 32'h0);
		print_verdict();
	end

	// Longest expected run is about a third of this span
	initial begin
		repeat (90000) @(posedge clk);
		failures++;
		print_verdict();
	end
endmodule // tb
